//--- shutdown_ctrl.sv
// shutdown mode power sequencer for the core supply domain
// assumes backup-domain inputs are synchronous to the always-on clock
`timescale 1ns/1ps
module shutdown_ctrl #(
	parameter int unsigned NUM_WAKE = shutdown_pkg::WAKE_PINS,
	parameter int unsigned RESTART_COUNT = shutdown_pkg::RESTART_CYCLES
) (
	input wire logic SYS_CLK, // always-on clock
	input wire logic RESET, // synchronous reset, active high
	input wire logic SHUTDOWN_REQ, // core asks for shutdown, pulse
	input wire logic KEEP_RTC, // 1 keeps real-time clock running
	input wire logic EXTERNAL_RESET_PIN_N, // external reset pin, active low
	input wire logic [NUM_WAKE-1:0] WAKE_PIN, // wake pin levels
	input wire logic [NUM_WAKE-1:0] WAKE_FALLING, // 1 selects falling edge
	input wire logic [NUM_WAKE-1:0] WAKE_ENABLE, // wake pin enables
	input wire logic RTC_ALARM, // real-time clock alarm event
	input wire logic RTC_PERIODIC, // periodic wakeup event
	input wire logic RTC_TIMESTAMP, // timestamp event
	input wire logic RTC_TAMPER, // tamper event
	output logic REGULATOR_ON, // core regulator enable
	output logic PLL_ON, // pll enable
	output logic INTERNAL_16MHZ_OSC_ON, // 16 MHz oscillator enable
	output logic MULTISPEED_OSC_ON, // multispeed oscillator enable
	output logic LOW_SPEED_OSC_ON, // low-speed internal oscillator enable
	output logic HIGH_SPEED_EXT_OSC_ON, // external oscillator enable
	output logic RTC_ON, // real-time clock run enable
	output logic MONITOR_ON, // brownout and supply monitors enable
	output logic BATTERY_SWITCH_EN, // backup battery switchover allowed
	output logic RAM_RETAIN, // main and second ram retention
	output logic BACKUP_RETAIN, // backup-domain registers retained
	output logic CORE_RESET, // core held in reset, active high
	output logic [1:0] SYSCLK_SRC, // system clock source select
	output logic [3:0] MULTISPEED_RANGE, // multispeed frequency range
	output logic IN_SHUTDOWN // block is in shutdown
);
	// ==========================================================
	// state
	typedef struct packed {
		shutdown_pkg::state_e state;
		logic rtc_kept;
		logic [15:0] count;
		logic [1:0] clksrc;
		logic [3:0] msi_range;
		logic [15:0] pu_cycles;
	} ctrl_s;
	ctrl_s q;
	ctrl_s next_q;
	logic [NUM_WAKE-1:0] pin_hit;
	logic wake;
	logic rtc_event;
	// latest cycle by which the core must leave reset after the hold
	localparam int RELEASE_MAX = int'(RESTART_COUNT);

	// ==========================================================
	// wake pins
	for (genvar i = 0; i < NUM_WAKE; i++) begin : g_wake
		wake_edge_detect u_edge (
			.clk(SYS_CLK),
			.rst(RESET),
			.pin(WAKE_PIN[i]),
			.falling(WAKE_FALLING[i]),
			.arm(WAKE_ENABLE[i] && q.state == shutdown_pkg::ST_SHUTDOWN),
			.event_hit(pin_hit[i])
		);
	end

	// rtc events only wake when the rtc was kept running
	assign rtc_event = q.rtc_kept &
		(RTC_ALARM | RTC_PERIODIC | RTC_TIMESTAMP | RTC_TAMPER);
	assign wake = ~EXTERNAL_RESET_PIN_N | (|pin_hit) | rtc_event;

	// ==========================================================
	// sequencer
	always_comb begin
		next_q = q;
		unique case (q.state)
			shutdown_pkg::ST_RUN: begin
				if (SHUTDOWN_REQ) begin
					next_q.state = shutdown_pkg::ST_SHUTDOWN;
					next_q.rtc_kept = KEEP_RTC;
				end
			end
			shutdown_pkg::ST_SHUTDOWN: begin
				if (wake) begin
					// full restart, not a resume
					next_q.state = shutdown_pkg::ST_POWERUP;
					next_q.count = 16'(RESTART_COUNT - 1);
					next_q.clksrc = shutdown_pkg::CLKSRC_MULTISPEED;
					next_q.msi_range = shutdown_pkg::MULTISPEED_4MHZ;
				end
			end
			shutdown_pkg::ST_POWERUP: begin
				if (q.count == 16'h0000) begin
					next_q.state = shutdown_pkg::ST_RUN;
				end else begin
					next_q.count = q.count - 16'h0001;
				end
			end
			default: next_q.state = shutdown_pkg::ST_RUN;
		endcase
		// power-up length counted apart from the down-counter, for the checks
		next_q.pu_cycles = (q.state == shutdown_pkg::ST_POWERUP) ?
			q.pu_cycles + 16'h0001 : 16'h0000;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			q.state <= shutdown_pkg::ST_RUN;
			q.rtc_kept <= 1'b1;
			q.count <= 16'h0000;
			q.clksrc <= shutdown_pkg::CLKSRC_MULTISPEED;
			q.msi_range <= shutdown_pkg::MULTISPEED_4MHZ;
			q.pu_cycles <= 16'h0000;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs
	logic sd;
	assign sd = q.state == shutdown_pkg::ST_SHUTDOWN;
	assign IN_SHUTDOWN = sd;
	assign REGULATOR_ON = ~sd;
	// every oscillator stops, the rtc alone may survive
	assign PLL_ON = ~sd;
	assign INTERNAL_16MHZ_OSC_ON = ~sd;
	assign MULTISPEED_OSC_ON = ~sd;
	assign LOW_SPEED_OSC_ON = ~sd;
	assign HIGH_SPEED_EXT_OSC_ON = ~sd;
	assign RTC_ON = ~sd | q.rtc_kept;
	assign MONITOR_ON = ~sd;
	assign BATTERY_SWITCH_EN = ~sd;
	assign RAM_RETAIN = ~sd;
	assign BACKUP_RETAIN = 1'b1;
	assign CORE_RESET = q.state != shutdown_pkg::ST_RUN;
	assign SYSCLK_SRC = q.clksrc;
	assign MULTISPEED_RANGE = q.msi_range;

	// ==========================================================
	// checks
	property p_regulator_off;
		@(posedge SYS_CLK) disable iff (RESET)
		sd |-> !REGULATOR_ON && !RAM_RETAIN;
	endproperty
	a_regulator_off: assert property (p_regulator_off)
		else $error("regulator or ram powered in shutdown");

	property p_osc_off;
		@(posedge SYS_CLK) disable iff (RESET)
		sd |-> !(PLL_ON | INTERNAL_16MHZ_OSC_ON | MULTISPEED_OSC_ON |
			LOW_SPEED_OSC_ON | HIGH_SPEED_EXT_OSC_ON);
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("oscillator running in shutdown");

	property p_rtc_variant;
		@(posedge SYS_CLK) disable iff (RESET)
		(q.state == shutdown_pkg::ST_RUN && SHUTDOWN_REQ) |=>
			sd && RTC_ON == $past(KEEP_RTC);
	endproperty
	a_rtc_variant: assert property (p_rtc_variant)
		else $error("rtc variant not honoured");

	property p_monitor_off;
		@(posedge SYS_CLK) disable iff (RESET)
		sd |-> !MONITOR_ON && !BATTERY_SWITCH_EN && BACKUP_RETAIN;
	endproperty
	a_monitor_off: assert property (p_monitor_off)
		else $error("monitoring active in shutdown");

	property p_reset_pin_wakes;
		@(posedge SYS_CLK) disable iff (RESET)
		(sd && !EXTERNAL_RESET_PIN_N) |=>
			q.state == shutdown_pkg::ST_POWERUP;
	endproperty
	a_reset_pin_wakes: assert property (p_reset_pin_wakes)
		else $error("reset pin did not wake");

	property p_rtc_wakes;
		@(posedge SYS_CLK) disable iff (RESET)
		(sd && RTC_ON && (RTC_ALARM | RTC_PERIODIC | RTC_TIMESTAMP |
			RTC_TAMPER)) |=> q.state == shutdown_pkg::ST_POWERUP;
	endproperty
	a_rtc_wakes: assert property (p_rtc_wakes)
		else $error("real-time clock event did not wake");

	property p_pin_edge;
		@(posedge SYS_CLK) disable iff (RESET)
		(sd && WAKE_ENABLE[0] && !WAKE_FALLING[0] && $rose(WAKE_PIN[0]))
			|=> !sd;
	endproperty
	a_pin_edge: assert property (p_pin_edge)
		else $error("rising wake edge missed");

	property p_clock_after_wake;
		@(posedge SYS_CLK) disable iff (RESET)
		$fell(sd) |-> SYSCLK_SRC == shutdown_pkg::CLKSRC_MULTISPEED &&
			MULTISPEED_RANGE == shutdown_pkg::MULTISPEED_4MHZ;
	endproperty
	a_clock_after_wake: assert property (p_clock_after_wake)
		else $error("wrong clock after wake");

	// a reset also drops these levels, so that edge is no wake or release
	sequence s_woke;
		$fell(sd) && !$past(RESET);
	endsequence
	sequence s_held;
		CORE_RESET [*8];
	endsequence
	sequence s_released;
		$fell(CORE_RESET) && !$past(RESET);
	endsequence
	// restart counts below eight would trip the hold part of this check
	property p_restart;
		@(posedge SYS_CLK) disable iff (RESET)
		s_woke |-> s_held ##[1:RELEASE_MAX] !CORE_RESET;
	endproperty
	a_restart: assert property (p_restart)
		else $error("core released without power-up sequence");

	property p_restart_length;
		@(posedge SYS_CLK) disable iff (RESET)
		s_released |-> q.pu_cycles == 16'(RESTART_COUNT);
	endproperty
	a_restart_length: assert property (p_restart_length)
		else $error("core released after wrong power-up length");
endmodule

//--- shutdown_pkg.sv
// shutdown power control package: states, counts and clock selections
// assumes a 25 MHz always-on clock feeding the controller
package shutdown_pkg;
	// ==========================================================
	// clock and timing
	localparam int unsigned SYS_CLK_HZ = 25000000;
	localparam int unsigned RESTART_NS = 2000;
	localparam int unsigned RESTART_CYCLES =
		(RESTART_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned WAKE_PINS = 5;
	// ==========================================================
	// system clock source after wake
	localparam logic [1:0] CLKSRC_MULTISPEED = 2'h0;
	localparam logic [3:0] MULTISPEED_4MHZ = 4'h6;
	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		ST_RUN,
		ST_SHUTDOWN,
		ST_POWERUP
	} state_e;
endpackage

//--- wake_edge_detect.sv
// edge detector for one wake pin with selectable polarity
// assumes the pin is synchronous to the clock
`timescale 1ns/1ps
module wake_edge_detect (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic pin, // wake pin level
	input wire logic falling, // 1 selects falling edge
	input wire logic arm, // detection enabled
	output logic event_hit // one-cycle wake event
);
	typedef struct packed {
		logic prev;
	} edge_s;
	edge_s q;
	edge_s next_q;

	always_comb begin
		next_q = q;
		next_q.prev = pin;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	// only edges seen while armed count
	assign event_hit = arm & (falling ? (q.prev & ~pin) : (~q.prev & pin));
endmodule

//--- wake_sources.sv
// model of the external reset pin and the wake pins
// assumes the bench calls its tasks just after a falling edge
`timescale 1ns/1ps
module wake_sources #(
	parameter int unsigned N = shutdown_pkg::WAKE_PINS
) (
	output logic reset_pin_n, // external reset pin, active low
	output logic [N-1:0] wake // wake pin levels
);
	initial begin
		reset_pin_n = 1'b1;
		wake = '0;
	end
	// level wake: one low cycle is enough for the sequencer
	task automatic set_reset(input logic v);
		reset_pin_n = v;
	endtask
	task automatic set_wake(input int i, input logic v);
		wake[i] = v;
	endtask
endmodule

//--- shutdown_mode_power_control_test.sv
// self-checking bench for the shutdown sequencer
// assumes a short restart count so each wake settles quickly
`timescale 1ns/1ps
module shutdown_mode_power_control_test;
	localparam int RC = 10;
	logic clk, rst, req, keep;
	logic [4:0] fall, ena, wk;
	logic [3:0] rtc;
	logic pin_n, r_on, pll, hsi, multispeed_internal_oscillator, low_speed_internal_oscillator, high_speed_external_oscillator, rtc_on, mon, bat, ram;
	logic bkp, crst, insd;
	logic [1:0] src;
	logic [3:0] rng;
	logic [8:0] en;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	assign en = {r_on, pll, hsi, multispeed_internal_oscillator, low_speed_internal_oscillator, high_speed_external_oscillator, mon, bat, ram};
	wake_sources i_src (.reset_pin_n(pin_n), .wake(wk));
	shutdown_ctrl #(.NUM_WAKE(5), .RESTART_COUNT(RC)) i_dut (
		.SYS_CLK(clk), .RESET(rst), .SHUTDOWN_REQ(req), .KEEP_RTC(keep),
		.EXTERNAL_RESET_PIN_N(pin_n), .WAKE_PIN(wk), .WAKE_FALLING(fall),
		.WAKE_ENABLE(ena), .RTC_ALARM(rtc[0]), .RTC_PERIODIC(rtc[1]),
		.RTC_TIMESTAMP(rtc[2]), .RTC_TAMPER(rtc[3]), .REGULATOR_ON(r_on),
		.PLL_ON(pll), .INTERNAL_16MHZ_OSC_ON(hsi), .MULTISPEED_OSC_ON(multispeed_internal_oscillator),
		.LOW_SPEED_OSC_ON(low_speed_internal_oscillator), .HIGH_SPEED_EXT_OSC_ON(high_speed_external_oscillator), .RTC_ON(rtc_on),
		.MONITOR_ON(mon), .BATTERY_SWITCH_EN(bat), .RAM_RETAIN(ram),
		.BACKUP_RETAIN(bkp), .CORE_RESET(crst), .SYSCLK_SRC(src),
		.MULTISPEED_RANGE(rng), .IN_SHUTDOWN(insd));
	// ==========================================================
	// checks and common steps
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic shut(input logic k);
		@(negedge clk);
		keep = k;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		chk(9'(insd), 9'h001);
		chk(en, 9'h000);
		chk(9'({rtc_on, bkp, crst}), 9'({k, 2'b11}));
		@(negedge clk);
	endtask
	task automatic still();
		repeat (3) @(negedge clk);
		chk(9'(insd), 9'h001);
	endtask
	// wake event was driven at the last falling edge
	task automatic waked();
		int n;
		n = 0;
		@(negedge clk);
		i_src.set_reset(1'b1);
		rtc = 4'h0;
		chk(9'(insd), 9'h000);
		chk(en, 9'h1ff);
		chk(9'(rtc_on), 9'h001);
		while (crst === 1'b1 && n < 200) begin
			n++;
			@(negedge clk);
		end
		chk(9'(n), 9'(RC));
		chk(9'({src, rng}), 9'h006);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_pins();
		for (int i = 0; i < 5; i++) begin
			ena = 5'h00;
			i_src.set_wake(i, fall[i]);
			shut(1'b1);
			i_src.set_wake(i, !fall[i]);
			still();
			ena[i] = 1'b1;
			@(negedge clk);
			i_src.set_wake(i, fall[i]);
			still();
			i_src.set_wake(i, !fall[i]);
			waked();
		end
		ena = 5'h00;
		$display("test wake pins done");
	endtask
	task automatic t_rtc();
		for (int i = 0; i < 4; i++) begin
			shut(1'b1);
			rtc[i] = 1'b1;
			waked();
		end
		shut(1'b0);
		rtc = 4'hf;
		still();
		rtc = 4'h0;
		i_src.set_reset(1'b0);
		waked();
		$display("test rtc and reset pin done");
	endtask
	// reset held for one edge while in shutdown without rtc
	task automatic t_reset();
		shut(1'b0);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk(9'({insd, crst, rtc_on}), 9'h001);
		chk(en, 9'h1ff);
		$display("test reset in shutdown done");
	endtask
	task automatic final_report();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			final_report();
		end
	end
	initial begin
		rst = 1'b1;
		req = 1'b0;
		keep = 1'b1;
		fall = 5'b01010;
		ena = 5'h00;
		rtc = 4'h0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk(en, 9'h1ff);
		t_pins();
		t_rtc();
		t_reset();
		final_report();
	end
endmodule
